/* File: common/alu_defines.svh */
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

// Register word offsets on the plain register port
`define ALU_ADDR_SRC     3'h0
`define ALU_ADDR_DST     3'h1
`define ALU_ADDR_CMD     3'h2
`define ALU_ADDR_FLAGS   3'h3
`define ALU_ADDR_STATUS  3'h4
`define ALU_ADDR_RESULT  3'h5

// Field positions
`define ALU_CMD_OP_LSB   0
`define ALU_CMD_OP_MSB   2
`define ALU_FLAGS_MSB    3
`define ALU_STAT_BUSY    0
`define ALU_STAT_WB      1
`define ALU_STAT_BIT16   2

// Reset values
`define ALU_DATA_RST     16'h0000
`define ALU_FLAGS_RST    4'h0
`define ALU_RES_RST      17'h00000

`endif

/* File: common/alu_pkg.sv */
package alu_pkg;

    // Operation codes as written to the command register
    typedef enum logic [2:0] {
        sum_word_op          = 3'b000,
        diff_word_op         = 3'b001,
        compare_word_op      = 3'b010,
        compare_byte_op      = 3'b011,
        inclusive_or_word_op = 3'b100,
        inclusive_or_byte_op = 3'b101
    } op_type;

    // Condition codes, negative in the top bit
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_type;

    // One finished operation
    typedef struct packed {
        logic [16:0] value;
        flags_type   flags;
        logic        write_back;
        logic        byte_op;
    } result_type;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_exec   = 2'b01,
        st_commit = 2'b10
    } state_type;

endpackage : alu_pkg

/* File: src/alu_flag_reg.sv */
`include "alu_defines.svh"

module alu_flag_reg (
    input  wire logic             i_clk,      // Processor clock
    input  wire logic             i_rst_n,    // Async reset, active low
    input  wire logic             i_hw_load,  // Operation commits flags
    input  wire alu_pkg::flags_type i_hw_flags, // Flags from the operation
    input  wire logic             i_sw_load,  // Software writes flags
    input  wire alu_pkg::flags_type i_sw_flags, // Flags from software
    output alu_pkg::flags_type    o_flags     // Current condition codes
);

    // Hardware load wins over a software write in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_flags <= `ALU_FLAGS_RST;
        else if (i_hw_load)
            o_flags <= i_hw_flags;
        else if (i_sw_load)
            o_flags <= i_sw_flags;
    end

endmodule : alu_flag_reg

/* File: src/alu_compute.sv */
`include "alu_defines.svh"

module alu_compute (
    input  wire logic             i_clk,   // Processor clock
    input  wire logic             i_rst_n, // Async reset, active low
    input  wire logic             i_start, // Compute this cycle
    input  wire alu_pkg::op_type  i_op,    // Operation
    input  wire logic [15:0]      i_src,   // Source operand
    input  wire logic [15:0]      i_dst,   // Destination operand
    input  wire logic             i_carry, // Carry flag before the op
    output alu_pkg::result_type   o_res    // Registered result and flags
);

    // a + ~b + 1 with the carry inverted, so bit 16 reads as a borrow
    function automatic logic [16:0] word_diff(input logic [15:0] a,
                                              input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, ~b} + 17'h00001; // RULE4
        word_diff = {~sum[16], sum[15:0]}; // RULE7
    endfunction : word_diff

    function automatic logic [8:0] byte_diff(input logic [7:0] a,
                                             input logic [7:0] b);
        logic [8:0] sum;
        sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
        byte_diff = {~sum[8], sum[7:0]};
    endfunction : byte_diff

    alu_pkg::result_type next_res;

    // Operation decode and flag forming
    always_comb
    begin
        logic [16:0] r;
        r = `ALU_RES_RST;
        next_res = '0;
        next_res.flags.c = i_carry;
        case (i_op)
            alu_pkg::sum_word_op:
            begin
                r = {1'b0, i_src} + {1'b0, i_dst}; // RULE17
                next_res.flags.v = (i_src[15] == i_dst[15])
                                 && (r[15] != i_src[15]);
                next_res.flags.c = r[16];
                next_res.write_back = 1'b1;
            end
            alu_pkg::diff_word_op:
            begin
                r = word_diff(i_dst, i_src); // RULE2
                next_res.flags.v = (i_src[15] != i_dst[15])
                                 && (r[15] == i_src[15]); // RULE5
                next_res.flags.c = r[16]; // RULE6
                next_res.write_back = 1'b1;
            end
            alu_pkg::compare_word_op:
            begin
                r = word_diff(i_src, i_dst); // RULE8
                next_res.flags.v = (i_src[15] != i_dst[15])
                                 && (r[15] == i_dst[15]); // RULE10
                next_res.flags.c = r[16]; // RULE11
            end
            alu_pkg::compare_byte_op:
            begin
                r = {8'h00, byte_diff(i_src[7:0], i_dst[7:0])}; // RULE12
                next_res.flags.v = (i_src[7] != i_dst[7])
                                 && (r[7] == i_dst[7]);
                next_res.flags.c = r[8];
                next_res.byte_op = 1'b1;
            end
            alu_pkg::inclusive_or_word_op:
            begin
                r = {1'b0, i_src | i_dst}; // RULE14
                next_res.write_back = 1'b1;
            end
            alu_pkg::inclusive_or_byte_op:
            begin
                r = {9'h000, i_src[7:0] | i_dst[7:0]}; // RULE18
                next_res.write_back = 1'b1;
                next_res.byte_op = 1'b1;
            end
            default:
            begin
                r = `ALU_RES_RST;
            end
        endcase
        next_res.value = r;
        // Sign and zero from the operand width in use
        if (next_res.byte_op)
        begin
            next_res.flags.n = r[7];
            next_res.flags.z = (r[7:0] == 8'h00);
        end
        else
        begin
            next_res.flags.n = r[15]; // RULE1
            next_res.flags.z = (r[15:0] == 16'h0000); // RULE15
        end
    end

    // Result holds until the next operation
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_res <= '0;
        else if (i_start)
            o_res <= next_res;
    end

endmodule : alu_compute

/* File: src/two_operand_alu_flags.sv */
// Summary of operation
// RULE1: Arithmetic sets N if negative, Z if zero
// RULE2: Difference writes destination minus source back
// RULE3: Difference never alters the source operand
// RULE4: Word difference is 17 bits wide
// RULE5: Difference overflow: signs differ, result like source
// RULE6: Difference carry set when no carry out
// RULE7: Set carry means borrow for multiword subtract
// RULE8: Compare is source plus inverted destination plus one
// RULE9: Compare only updates flags, no write back
// RULE10: Compare overflow: signs differ, result like destination
// RULE11: Word compare carry from bit 16, inverted
// RULE12: Byte compare uses low bytes, 9 bits
// RULE13: Logical ops share the two operand format
// RULE14: Inclusive OR stores source OR destination
// RULE15: Inclusive OR sets N, Z from result
// RULE16: Inclusive OR clears V, keeps C
// RULE17: Sum adds, carry bit 16, overflow on sign
// RULE18: Byte OR works on low bytes only
`include "alu_defines.svh"

module two_operand_alu_flags #(
    parameter int DATA_W = 16 // Operand width
) (
    input  wire logic              i_clk,   // 200 MHz processor clock
    input  wire logic              i_rst_n, // Async reset, active low
    input  wire logic [2:0]        i_addr,  // Register word offset
    input  wire logic [DATA_W-1:0] i_wdata, // Write data
    input  wire logic              i_wr,    // Write strobe
    input  wire logic              i_rd,    // Read strobe
    output logic [DATA_W-1:0]      o_rdata, // Read data, cycle after read
    output alu_pkg::flags_type     o_flags, // Condition codes
    output logic                   o_busy,  // Operation in progress
    output logic                   o_done   // One cycle at completion
);

    alu_pkg::state_type  state;
    alu_pkg::state_type  next_state;
    alu_pkg::op_type     op_reg;
    alu_pkg::result_type res;
    logic [DATA_W-1:0]   src_reg;
    logic [DATA_W-1:0]   dst_reg;
    logic                accept;
    logic                commit;
    logic                wb_last;

    // Codes 6 and 7 are not operations; such a command is dropped
    function automatic logic op_known(input logic [2:0] code);
        op_known = (code <= 3'h5);
    endfunction : op_known

    function automatic logic is_compare(input alu_pkg::op_type op);
        is_compare = (op == alu_pkg::compare_word_op)
                   || (op == alu_pkg::compare_byte_op);
    endfunction : is_compare

    // A command is taken only when idle and known
    assign accept = (state == alu_pkg::st_idle) && i_wr
                  && (i_addr == `ALU_ADDR_CMD)
                  && op_known(i_wdata[`ALU_CMD_OP_MSB:`ALU_CMD_OP_LSB]);
    assign commit = (state == alu_pkg::st_commit);

    // Sequencer: take command, compute, commit
    always_comb
    begin
        next_state = state;
        case (state)
            alu_pkg::st_idle:
            begin
                if (accept)
                    next_state = alu_pkg::st_exec;
            end
            alu_pkg::st_exec:
            begin
                next_state = alu_pkg::st_commit;
            end
            alu_pkg::st_commit:
            begin
                next_state = alu_pkg::st_idle;
            end
            default:
            begin
                next_state = alu_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state <= alu_pkg::st_idle;
        else
            state <= next_state;
    end

    // Status outputs are flops so the port never sees decode glitches
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_busy <= (next_state != alu_pkg::st_idle);
            o_done <= commit;
        end
    end

    // Operation code latched when the command is taken
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            op_reg <= alu_pkg::sum_word_op;
        else if (accept)
            op_reg <= alu_pkg::op_type'(
                i_wdata[`ALU_CMD_OP_MSB:`ALU_CMD_OP_LSB]); // RULE13
    end

    // Source is written by software only
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            src_reg <= `ALU_DATA_RST;
        else if (i_wr && (i_addr == `ALU_ADDR_SRC))
            src_reg <= i_wdata; // RULE3
    end

    // Destination: write back wins over a software write
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            dst_reg <= `ALU_DATA_RST;
        else if (commit && res.write_back)
        begin
            if (res.byte_op)
                dst_reg <= {dst_reg[15:8], res.value[7:0]}; // RULE18
            else
                dst_reg <= res.value[15:0]; // RULE2
        end
        else if (i_wr && (i_addr == `ALU_ADDR_DST))
            dst_reg <= i_wdata;
    end

    // Remembers whether the last operation wrote the destination
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wb_last <= 1'b0;
        else if (commit)
            wb_last <= res.write_back; // RULE9
    end

    // Arithmetic and flag forming
    alu_compute u_compute (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (state == alu_pkg::st_exec),
        .i_op    (op_reg),
        .i_src   (src_reg),
        .i_dst   (dst_reg),
        .i_carry (o_flags.c), // RULE16
        .o_res   (res)
    );

    // Software may preset the flags; only inclusive OR keeps the preset carry
    alu_flag_reg u_flags (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_hw_load  (commit),
        .i_hw_flags (res.flags),
        .i_sw_load  (i_wr && (i_addr == `ALU_ADDR_FLAGS)),
        .i_sw_flags (alu_pkg::flags_type'(i_wdata[`ALU_FLAGS_MSB:0])),
        .o_flags    (o_flags) // RULE7
    );

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= `ALU_DATA_RST;
        else if (!i_rd)
            o_rdata <= `ALU_DATA_RST;
        else if (i_addr == `ALU_ADDR_SRC)
            o_rdata <= src_reg;
        else if (i_addr == `ALU_ADDR_DST)
            o_rdata <= dst_reg;
        else if (i_addr == `ALU_ADDR_CMD)
            o_rdata <= {13'h0000, op_reg};
        else if (i_addr == `ALU_ADDR_FLAGS)
            o_rdata <= {12'h000, o_flags};
        else if (i_addr == `ALU_ADDR_STATUS)
            o_rdata <= {13'h0000, res.value[16], wb_last, o_busy};
        else if (i_addr == `ALU_ADDR_RESULT)
            o_rdata <= res.value[15:0];
        else
            o_rdata <= `ALU_DATA_RST;
    end

    // Sum value, carry and overflow against the operands
    a_sum_result: assert property ( // RULE17
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::sum_word_op)
        |=> res.value == ({1'b0, $past(src_reg)} + {1'b0, $past(dst_reg)})
            && res.flags.c == res.value[16]
            && res.flags.v == (($past(src_reg[15]) == $past(dst_reg[15]))
                && (res.value[15] != $past(src_reg[15]))))
        else $error("sum result or flags wrong");

    // Difference is destination minus source
    a_diff_value: assert property ( // RULE4
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::diff_word_op)
        |=> res.value[15:0] == 16'($past(dst_reg) - $past(src_reg))
            && res.flags.n == res.value[15])
        else $error("difference value wrong");

    // Difference overflow follows the source sign
    a_diff_overflow: assert property ( // RULE5
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::diff_word_op)
        |=> res.flags.v == (($past(src_reg[15]) != $past(dst_reg[15]))
            && (res.value[15] == $past(src_reg[15]))))
        else $error("difference overflow wrong");

    // Difference carry is the borrow
    a_diff_borrow: assert property ( // RULE6
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::diff_word_op)
        |=> res.flags.c == ($past(dst_reg) < $past(src_reg)))
        else $error("difference carry wrong");

    // Compare runs the other way round
    a_cmp_order: assert property ( // RULE8
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::compare_word_op)
        |=> res.value[15:0] == 16'($past(src_reg) - $past(dst_reg))
            && res.flags.c == ($past(src_reg) < $past(dst_reg)))
        else $error("compare order or carry wrong");

    // Compare overflow follows the destination sign
    a_cmp_overflow: assert property ( // RULE10
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::compare_word_op)
        |=> res.flags.v == (($past(src_reg[15]) != $past(dst_reg[15]))
            && (res.value[15] == $past(dst_reg[15]))))
        else $error("compare overflow wrong");

    // Byte compare value and flags from the nine bit difference
    a_byte_cmp: assert property ( // RULE12
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::compare_byte_op)
        |=> res.value[8:0] == 9'({1'b0, $past(src_reg[7:0])}
                - {1'b0, $past(dst_reg[7:0])})
            && res.flags.c == res.value[8] && res.flags.n == res.value[7]
            && res.flags.z == (res.value[7:0] == 8'h00))
        else $error("byte compare flags wrong");

    // Byte compare overflow uses the byte signs
    a_byte_cmp_ovf: assert property ( // RULE12
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec && op_reg == alu_pkg::compare_byte_op)
        |=> res.flags.v == (($past(src_reg[7]) != $past(dst_reg[7]))
            && (res.value[7] == $past(dst_reg[7]))))
        else $error("byte compare overflow wrong");

    // Compare leaves the destination alone
    a_cmp_no_write: assert property ( // RULE9
        @(posedge i_clk) disable iff (!i_rst_n)
        (commit && is_compare(op_reg)
            && !(i_wr && i_addr == `ALU_ADDR_DST))
        |=> $stable(dst_reg) && !wb_last)
        else $error("compare changed destination");

    // Source only moves on a software write
    a_src_kept: assert property ( // RULE3
        @(posedge i_clk) disable iff (!i_rst_n)
        !(i_wr && i_addr == `ALU_ADDR_SRC) |=> $stable(src_reg))
        else $error("source changed");

    // Inclusive OR value, cleared overflow, kept carry
    a_or_word: assert property ( // RULE16
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec
            && op_reg == alu_pkg::inclusive_or_word_op)
        |=> res.value[15:0] == ($past(src_reg) | $past(dst_reg))
            && !res.flags.v && res.flags.c == $past(o_flags.c))
        else $error("inclusive or result wrong");

    // Byte OR: low bytes only, byte flags, carry kept
    a_or_byte: assert property ( // RULE18
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec
            && op_reg == alu_pkg::inclusive_or_byte_op)
        |=> res.value[7:0] == ($past(src_reg[7:0]) | $past(dst_reg[7:0]))
            && res.flags.n == res.value[7] && !res.flags.v
            && res.flags.z == (res.value[7:0] == 8'h00)
            && res.flags.c == $past(o_flags.c))
        else $error("byte inclusive or result wrong");

    // Word write back replaces the whole destination
    a_word_wb: assert property ( // RULE2
        @(posedge i_clk) disable iff (!i_rst_n)
        (commit && res.write_back && !res.byte_op)
        |=> dst_reg == $past(res.value[15:0]))
        else $error("word write back wrong");

    // Byte write back keeps the high destination byte
    a_byte_wb: assert property ( // RULE18
        @(posedge i_clk) disable iff (!i_rst_n)
        (commit && res.write_back && res.byte_op)
        |=> dst_reg[15:8] == $past(dst_reg[15:8])
            && dst_reg[7:0] == $past(res.value[7:0]))
        else $error("byte write back wrong");

    // Arithmetic sign and zero flags for every word operation
    a_sign_zero: assert property ( // RULE1
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == alu_pkg::st_exec
            && op_reg != alu_pkg::compare_byte_op
            && op_reg != alu_pkg::inclusive_or_byte_op)
        |=> res.flags.n == res.value[15]
            && res.flags.z == (res.value[15:0] == 16'h0000))
        else $error("sign or zero flag wrong");

    // Every commit, compare included, updates the condition codes
    a_flag_commit: assert property ( // RULE9
        @(posedge i_clk) disable iff (!i_rst_n)
        commit |=> o_flags == $past(res.flags))
        else $error("flags not taken at commit");

    // Read data are zero outside the answer cycle
    a_rdata_idle: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_rd |=> o_rdata == `ALU_DATA_RST)
        else $error("read data not zero when idle");

    // Flags and write back land three cycles after the command
    a_cmd_timing: assert property ( // RULE13
        @(posedge i_clk) disable iff (!i_rst_n)
        accept |=> o_busy ##1 o_busy ##1 (!o_busy && o_done
            && o_flags == $past(res.flags)))
        else $error("command timing wrong");

endmodule : two_operand_alu_flags

/* File: tb/two_operand_alu_flags_tb.sv */
`include "alu_defines.svh"

module two_operand_alu_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic               i_clk;
    logic               i_rst_n;
    logic [2:0]         i_addr;
    logic [15:0]        i_wdata;
    logic               i_wr;
    logic               i_rd;
    logic [15:0]        o_rdata;
    alu_pkg::flags_type o_flags;
    logic               o_busy;
    logic               o_done;
    int                 mismatches;
    int                 check_count;
    logic [15:0]        rd_val;
    // Boundary operands: zero, sign edges, all ones, byte sign edge
    logic [15:0]        edge_q[$] = '{16'h0000, 16'h8000, 16'h7fff,
                                      16'hffff, 16'h0001, 16'h0080};

    two_operand_alu_flags #(.DATA_W(16)) uut (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_addr  (i_addr),
        .i_wdata (i_wdata),
        .i_wr    (i_wr),
        .i_rd    (i_rd),
        .o_rdata (o_rdata),
        .o_flags (o_flags),
        .o_busy  (o_busy),
        .o_done  (o_done)
    );

    // 200 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic chk(input string name, input logic [16:0] seen,
                       input logic [16:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // One-cycle write; strobe drops on the next edge
    task automatic bus_wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : bus_wr

    // Read data only stands in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [2:0] a,
                          input logic [15:0] exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        rd_val = o_rdata;
        chk(name, {1'b0, rd_val}, {1'b0, exp});
    endtask : rd_chk

    // Reference: dst, intermediate low word, flags, write back, bit 16
    task automatic model(input logic [2:0] op, input logic [15:0] s,
                         input logic [15:0] d, input logic cin,
                         output logic [15:0] ed, output logic [15:0] er,
                         output logic [3:0] ef, output logic wb,
                         output logic b16);
        logic [16:0] r;
        logic [8:0]  r9;
        logic        v;
        r   = 17'h00000;
        r9  = 9'h000;
        v   = 1'b0;
        case (op)
            3'h0: r = {1'b0, s} + {1'b0, d};
            3'h1: r = {1'b0, d} - {1'b0, s};
            3'h2: r = {1'b0, s} - {1'b0, d};
            3'h4: r = {1'b0, s | d};
            default: r9 = (op == 3'h3) ? {1'b0, s[7:0]} - {1'b0, d[7:0]}
                                       : {1'b0, s[7:0] | d[7:0]};
        endcase
        case (op)
            3'h0: v = (s[15] == d[15]) && (r[15] != s[15]);
            3'h1: v = (s[15] != d[15]) && (r[15] == s[15]);
            3'h2: v = (s[15] != d[15]) && (r[15] == d[15]);
            3'h3: v = (s[7] != d[7]) && (r9[7] == d[7]);
            default: v = 1'b0;
        endcase
        wb  = (op == 3'h0) || (op == 3'h1) || (op >= 3'h4);
        b16 = (op <= 3'h2) ? r[16] : 1'b0;
        if (op == 3'h3 || op == 3'h5)
        begin
            er = {7'h00, r9};
            ef = {r9[7], r9[7:0] == 8'h00, v, (op == 3'h3) ? r9[8] : cin};
            ed = (op == 3'h5) ? {d[15:8], r9[7:0]} : d;
        end
        else
        begin
            er = r[15:0];
            ef = {r[15], r[15:0] == 16'h0000, v, (op == 3'h4) ? cin : r[16]};
            ed = wb ? r[15:0] : d;
        end
    endtask : model

    // Full operation through the register port, then compare everything except the result register for byte OR
    task automatic run_op(input logic [2:0] op, input logic [15:0] s,
                          input logic [15:0] d);
        logic [15:0] ed;
        logic [15:0] er;
        logic [3:0]  ef;
        logic [3:0]  fl;
        logic        wb;
        logic        b16;
        int          n;
        fl = 4'($urandom());
        model(op, s, d, fl[0], ed, er, ef, wb, b16);
        bus_wr(`ALU_ADDR_SRC, s);
        bus_wr(`ALU_ADDR_DST, d);
        bus_wr(`ALU_ADDR_FLAGS, {12'h000, fl});
        #1;
        chk("flags_sw", {13'h0000, o_flags}, {13'h0000, fl});
        bus_wr(`ALU_ADDR_CMD, {13'h0000, op});
        n = 1;
        #1;
        chk("busy", {16'h0000, o_busy}, 17'h00001);
        while (o_done !== 1'b1 && n < 10)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("done_lat", 17'(n), 17'h00003);
        chk("fl_n", 17'(o_flags.n), 17'(ef[3]));
        chk("fl_z", 17'(o_flags.z), 17'(ef[2]));
        chk("fl_v", 17'(o_flags.v), 17'(ef[1]));
        chk("fl_c", 17'(o_flags.c), 17'(ef[0]));
        @(posedge i_clk);
        #1;
        chk("done_pulse", {16'h0000, o_done}, 17'h00000);
        rd_chk("dst", `ALU_ADDR_DST, ed);
        rd_chk("src", `ALU_ADDR_SRC, s);
        if (op != 3'h5)
            rd_chk("result", `ALU_ADDR_RESULT, er);
        rd_chk("status", `ALU_ADDR_STATUS,
               {13'h0, b16, wb, 1'b0});
        rd_chk("cmd", `ALU_ADDR_CMD, {13'h0000, op});
    endtask : run_op

    // Main sequence
    initial
    begin
        i_rst_n = 1'b0;
        i_addr  = 3'h0;
        i_wdata = 16'h0000;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        void'($urandom(58375));
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("rst_flags", {13'h0000, o_flags}, 17'h00000);
        chk("rst_busy", {15'h0000, o_busy, o_done}, 17'h00000);
        rd_chk("rst_dst", `ALU_ADDR_DST, 16'h0000);
        rd_chk("unmapped", 3'h6, 16'h0000);
        // Every op over boundary pairs, then random operands
        for (int op = 0; op < 6; op++)
        begin
            foreach (edge_q[i])
                foreach (edge_q[j])
                    run_op(3'(op), edge_q[i], edge_q[j]);
            repeat (20)
                run_op(3'(op), 16'($urandom()), 16'($urandom()));
        end
        // Undefined op code must not start anything
        bus_wr(`ALU_ADDR_CMD, 16'h0007);
        #1;
        chk("bad_op_busy", {16'h0000, o_busy}, 17'h00000);
        repeat (3) @(posedge i_clk);
        #1;
        chk("bad_op_done", {16'h0000, o_done}, 17'h00000);
        // Command while busy is dropped: sum result survives
        bus_wr(`ALU_ADDR_SRC, 16'h0001);
        bus_wr(`ALU_ADDR_DST, 16'h0002);
        bus_wr(`ALU_ADDR_CMD, 16'h0000);
        bus_wr(`ALU_ADDR_CMD, 16'h0001);
        #1;
        chk("busy_done", {16'h0000, o_done}, 17'h00001);
        repeat (4) @(posedge i_clk);
        rd_chk("busy_dst", `ALU_ADDR_DST, 16'h0003);
        rd_chk("busy_cmd", `ALU_ADDR_CMD, 16'h0000);
        complete_run();
    end

    // Watchdog, well beyond the expected run length
    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end

endmodule : two_operand_alu_flags_tb
